// ### core/kbd_ctrl_pkg.sv
// Purpose: shared constants for the keyboard controller status/config block
// Assumes: 8-bit host command and data ports, one core clock
// Notes:   bit positions and codes are used by the main block and its translator
package kbd_ctrl_pkg;
  localparam logic [7:0] CMD_READ_CFG    = 8'h20;
  localparam logic [7:0] CMD_WRITE_CFG   = 8'h60;
  localparam int         CFG_RSVD_BIT    = 7;
  localparam int         CFG_XLATE_BIT   = 6;
  localparam int         CFG_MOUSE_DIS   = 5;
  localparam logic [7:0] CFG_RESET       = 8'h00;
  localparam logic [7:0] CFG_WRITE_MASK  = 8'h7f;
  localparam int         STAT_PARITY_BIT = 7;
  localparam int         STAT_TMO_BIT    = 6;
  localparam logic [7:0] BREAK_PREFIX    = 8'hf0;
  localparam logic [7:0] BREAK_FLAG      = 8'h80;
  localparam int         TABLE_DEPTH     = 256;

  typedef enum logic [0:0] {
    CMD_IDLE     = 1'b0,
    CMD_WAIT_CFG = 1'b1
  } cmd_state_t;
endpackage

// ### core/kbd_ctrl_status.sv
// Purpose: status parity/timeout bits and upper configuration byte bits
// Assumes: link receivers deliver whole bytes with their parity bit
// Notes:   one output-buffer slot; config read beats a received byte
module kbd_ctrl_status (
  input  wire logic       core_clk,        // core clock
  input  wire logic       reset,           // sync reset, active high
  input  wire logic       cmdValid,        // host command strobe
  input  wire logic [7:0] cmdCode,         // host command byte
  input  wire logic       dataValid,       // host data-port write strobe
  input  wire logic [7:0] dataIn,          // host data byte
  input  wire logic       rxValid,         // byte from keyboard/mouse link
  input  wire logic [7:0] rxData,          // received byte
  input  wire logic       rxParity,        // received parity bit
  input  wire logic       rxFromMouse,     // byte came from the mouse
  output logic            rxReady,         // link byte can be taken
  input  wire logic       linkTimeout,     // link timeout pulse
  input  wire logic       tblWe,           // translation table write
  input  wire logic [7:0] tblAddr,         // table index
  input  wire logic [7:0] tblData,         // table value
  output logic            outValid,        // output buffer load pulse
  output logic      [7:0] outData,         // output buffer byte
  output logic            outMouse,        // byte is mouse data
  output logic            statusParityErr, // status bit 7
  output logic            statusTimeout,   // status bit 6
  output logic      [7:0] configByte,      // config byte as read back
  output logic            translateOn,     // scan translation active
  output logic            mouseEnable      // mouse interface enabled
);
  kbd_ctrl_pkg::cmd_state_t cmdState;
  logic [7:0] cfg;
  logic       cfgRead;
  logic       accept;
  logic       mouseDropped;
  logic       kbByte;
  logic       useByte;
  logic       prefixByte;
  logic [7:0] transCode;

  // true when data plus parity hold an odd count of ones
  function automatic logic oddTotal(input logic [7:0] d, input logic p);
    return ^{d, p};
  endfunction

  assign cfgRead      = cmdValid && (cmdCode == kbd_ctrl_pkg::CMD_READ_CFG);
  // no second slot: a link byte waits while a config read owns the buffer
  assign rxReady      = !cfgRead;
  assign accept       = rxValid && rxReady;
  assign mouseDropped = rxFromMouse && cfg[kbd_ctrl_pkg::CFG_MOUSE_DIS];
  assign kbByte       = accept && !rxFromMouse;
  assign useByte      = accept && !mouseDropped;
  assign configByte   = cfg & kbd_ctrl_pkg::CFG_WRITE_MASK;
  assign translateOn  = cfg[kbd_ctrl_pkg::CFG_XLATE_BIT];
  assign mouseEnable  = !cfg[kbd_ctrl_pkg::CFG_MOUSE_DIS];

  scan_translate u_xlate (
    .core_clk   (core_clk),
    .reset      (reset),
    .enable     (translateOn),
    .inValid    (kbByte),
    .inCode     (rxData),
    .tblWe      (tblWe),
    .tblAddr    (tblAddr),
    .tblData    (tblData),
    .outCode    (transCode),
    .prefixByte (prefixByte)
  );

  // a write command arms the next data-port byte as the config value
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cmdState <= kbd_ctrl_pkg::CMD_IDLE;
    end else begin
      unique case (cmdState)
        kbd_ctrl_pkg::CMD_IDLE: begin
          if (cmdValid && cmdCode == kbd_ctrl_pkg::CMD_WRITE_CFG) begin
            cmdState <= kbd_ctrl_pkg::CMD_WAIT_CFG;
          end
        end
        kbd_ctrl_pkg::CMD_WAIT_CFG: begin
          if (dataValid) begin
            cmdState <= kbd_ctrl_pkg::CMD_IDLE;
          end else if (cmdValid && cmdCode != kbd_ctrl_pkg::CMD_WRITE_CFG) begin
            cmdState <= kbd_ctrl_pkg::CMD_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfg <= kbd_ctrl_pkg::CFG_RESET;
    end else if (cmdState == kbd_ctrl_pkg::CMD_WAIT_CFG && dataValid) begin
      cfg <= dataIn & kbd_ctrl_pkg::CFG_WRITE_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      outValid <= 1'b0;
      outData  <= 8'h00;
      outMouse <= 1'b0;
    end else begin
      outValid <= 1'b0;
      if (cfgRead) begin
        outValid <= 1'b1;
        outData  <= configByte;
        outMouse <= 1'b0;
      end else if (useByte && !(kbByte && prefixByte)) begin
        outValid <= 1'b1;
        outMouse <= rxFromMouse;
        if (kbByte && translateOn) begin
          outData <= transCode;
        end else begin
          outData <= rxData;
        end
      end
    end
  end

  // odd total over data and parity means a clean byte
  always_ff @(posedge core_clk) begin
    if (reset) begin
      statusParityErr <= 1'b0;
    end else if (useByte) begin
      statusParityErr <= !oddTotal(rxData, rxParity);
    end
  end

  // a timeout in the same cycle as a clean byte still sets the flag
  always_ff @(posedge core_clk) begin
    if (reset) begin
      statusTimeout <= 1'b0;
    end else if (linkTimeout) begin
      statusTimeout <= 1'b1;
    end else if (useByte) begin
      statusTimeout <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_parity_odd: assert property (
    useByte && oddTotal(rxData, rxParity) |=> !statusParityErr)
    else $error("parity flag set after odd-parity byte");
  a_parity_even: assert property (
    useByte && !oddTotal(rxData, rxParity)
    |=> statusParityErr ##1 (statusParityErr || $past(useByte)))
    else $error("parity flag not set after even-parity byte");
  // reset checks must not be switched off by the reset they watch
  a_parity_reset: assert property (
    @(posedge core_clk) disable iff (1'b0) reset |=> !statusParityErr)
    else $error("parity flag not clear after reset");
  a_reset_state: assert property (
    @(posedge core_clk) disable iff (1'b0)
    reset |=> !statusTimeout && !outValid && configByte == kbd_ctrl_pkg::CFG_RESET)
    else $error("status or config not at reset value");
  a_cfg_read: assert property (
    cfgRead |=> outValid && !outMouse && outData == $past(configByte))
    else $error("config read did not return config byte");
  a_cfg_write: assert property (
    cmdValid && cmdCode == kbd_ctrl_pkg::CMD_WRITE_CFG && !(cmdState == kbd_ctrl_pkg::CMD_WAIT_CFG && dataValid)
    ##1 (dataValid && !cmdValid)
    |=> configByte == ($past(dataIn) & kbd_ctrl_pkg::CFG_WRITE_MASK))
    else $error("config write not applied");
  a_rsvd_zero: assert property (
    cfgRead |=> !outData[kbd_ctrl_pkg::CFG_RSVD_BIT])
    else $error("reserved config bit read as one");
  a_pass_thru: assert property (
    kbByte && !translateOn |=> outValid && outData == $past(rxData))
    else $error("untranslated keyboard byte altered");
  a_translate: assert property (
    kbByte && translateOn && !prefixByte |=> outValid && outData == $past(transCode))
    else $error("translated code not delivered");
  // checker memory: bytes may be spaced, so remember the prefix across gaps
  logic prefixSeen;
  always_ff @(posedge core_clk) begin
    if (reset || !translateOn) begin
      prefixSeen <= 1'b0;
    end else if (kbByte) begin
      prefixSeen <= (rxData == kbd_ctrl_pkg::BREAK_PREFIX);
    end
  end
  a_break_merge: assert property (
    prefixSeen && translateOn && kbByte && rxData != kbd_ctrl_pkg::BREAK_PREFIX
    |=> outValid && outData == ($past(transCode) | kbd_ctrl_pkg::BREAK_FLAG))
    else $error("break sequence not merged");
  a_prefix_drop: assert property (
    kbByte && translateOn && rxData == kbd_ctrl_pkg::BREAK_PREFIX |=> !outValid)
    else $error("break prefix reached the output buffer");
  a_mouse_on: assert property (
    accept && rxFromMouse && mouseEnable |=> outValid && outMouse)
    else $error("mouse byte lost while enabled");
  a_mouse_off: assert property (
    accept && mouseDropped |=> !outValid)
    else $error("mouse byte passed while disabled");
  a_timeout_set: assert property (linkTimeout |=> statusTimeout)
    else $error("timeout not reported");
  a_timeout_clear: assert property (
    useByte && !linkTimeout |=> !statusTimeout)
    else $error("timeout flag not cleared by a clean byte");
  a_timeout_hold: assert property (
    !useByte && !linkTimeout |=> $stable(statusTimeout))
    else $error("timeout flag changed with no event");
  a_parity_hold: assert property (
    !useByte |=> $stable(statusParityErr))
    else $error("parity flag changed with no received byte");
  a_mouse_raw: assert property (
    accept && rxFromMouse && mouseEnable |=> outData == $past(rxData))
    else $error("mouse byte altered on its way to the buffer");
  a_cfg_hold: assert property (
    !(cmdState == kbd_ctrl_pkg::CMD_WAIT_CFG && dataValid) |=> $stable(configByte))
    else $error("config byte changed without a write");

  c_cfg_read:  cover property (cfgRead ##1 outValid);
  c_break:     cover property (prefixSeen && kbByte ##1 outValid);
  c_stall:     cover property (rxValid && !rxReady);
  c_mouse_off: cover property (accept && mouseDropped);
  c_par_err:   cover property (useByte ##1 statusParityErr);
endmodule

// ### core/scan_translate.sv
// Purpose: scan-code translation table and break-prefix merging
// Assumes: table contents loaded by system firmware; identity after reset
// Notes:   outCode and prefixByte are combinational from inCode
module scan_translate (
  input  wire logic       core_clk,   // core clock
  input  wire logic       reset,      // sync reset, active high
  input  wire logic       enable,     // translation turned on
  input  wire logic       inValid,    // keyboard byte taken this cycle
  input  wire logic [7:0] inCode,     // received keyboard byte
  input  wire logic       tblWe,      // table write strobe
  input  wire logic [7:0] tblAddr,    // table write index
  input  wire logic [7:0] tblData,    // table write value
  output logic      [7:0] outCode,    // translated code
  output logic            prefixByte  // byte is a break prefix, swallow it
);
  logic [7:0] codeTable [kbd_ctrl_pkg::TABLE_DEPTH];
  logic       breakPending;

  // identity at reset so an unloaded table still passes codes through
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < kbd_ctrl_pkg::TABLE_DEPTH; i++) begin
        codeTable[i] <= 8'(i);
      end
    end else if (tblWe) begin
      codeTable[tblAddr] <= tblData;
    end
  end

  assign prefixByte = enable && (inCode == kbd_ctrl_pkg::BREAK_PREFIX);

  always_ff @(posedge core_clk) begin
    if (reset || !enable) begin
      breakPending <= 1'b0;
    end else if (inValid) begin
      breakPending <= prefixByte;
    end
  end

  always_comb begin
    outCode = codeTable[inCode];
    if (breakPending) begin
      outCode = outCode | kbd_ctrl_pkg::BREAK_FLAG;
    end
  end
endmodule

// ### tb/kbd_ctrl_status_tb.sv
// Purpose: directed checks of status and config bits of the controller block
// Assumes: link bytes come from link_dev_model
// Notes:   output buffer loads are caught by a monitor
module kbd_ctrl_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk = 0, reset = 1, cmdValid = 0, dataValid = 0, linkTimeout = 0;
  logic       tblWe = 0, sendReq = 0, sendMouse = 0, sendBad = 0, lastMouse = 0;
  logic [7:0] cmdCode = 0, dataIn = 0, tblAddr = 0, tblData = 0, sendByte = 0, lastOut = 0;
  logic       rxValid, rxParity, rxFromMouse, rxReady, outValid, outMouse;
  logic       statusParityErr, statusTimeout, translateOn, mouseEnable;
  logic [7:0] rxData, outData, configByte;
  int         failures = 0, n_compared = 0, nOut = 0, n;
  always #50 core_clk = ~core_clk;
  kbd_ctrl_status u_kbd_ctrl_status (.core_clk(core_clk), .reset(reset), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .dataValid(dataValid), .dataIn(dataIn), .rxValid(rxValid),
    .rxData(rxData), .rxParity(rxParity), .rxFromMouse(rxFromMouse), .rxReady(rxReady),
    .linkTimeout(linkTimeout), .tblWe(tblWe), .tblAddr(tblAddr), .tblData(tblData),
    .outValid(outValid), .outData(outData), .outMouse(outMouse),
    .statusParityErr(statusParityErr), .statusTimeout(statusTimeout),
    .configByte(configByte), .translateOn(translateOn), .mouseEnable(mouseEnable));
  link_dev_model u_link_dev_model (.core_clk(core_clk), .sendReq(sendReq),
    .sendByte(sendByte), .sendMouse(sendMouse), .sendBad(sendBad), .rxReady(rxReady),
    .rxValid(rxValid), .rxData(rxData), .rxParity(rxParity), .rxFromMouse(rxFromMouse));
  always @(posedge core_clk) begin
    if (outValid === 1'b1) begin
      lastOut   <= outData;
      lastMouse <= outMouse;
      nOut      <= nOut + 1;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdCode  <= c;
    @(posedge core_clk);
    cmdValid <= 1'b0;
  endtask
  task automatic cfgw(input logic [7:0] d);
    cmd(8'h60);
    dataValid <= 1'b1;
    dataIn    <= d;
    @(posedge core_clk);
    dataValid <= 1'b0;
  endtask
  task automatic cfgr(input logic [7:0] e);
    cmd(8'h20);
    repeat (2) @(negedge core_clk);
    chk(lastOut, e);
  endtask
  // fixed wait: taken and loaded one edge after the model presents, seen by the monitor the next
  task automatic send(input logic [7:0] b, input logic m, input logic bad);
    @(posedge core_clk);
    sendReq   <= 1'b1;
    sendByte  <= b;
    sendMouse <= m;
    sendBad   <= bad;
    @(posedge core_clk);
    sendReq <= 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic final_report;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    chk(configByte, 8'h00);
    chk({4'h0, statusParityErr, statusTimeout, translateOn, mouseEnable}, 8'h01);
    $display("test reset done");
    cfgw(8'hff);
    cfgr(8'h7f);
    chk({6'h0, translateOn, mouseEnable}, 8'h02);
    $display("test config done");
    cfgw(8'h00);
    send(8'h1c, 1'b0, 1'b0);
    chk(lastOut, 8'h1c);
    chk({7'h0, statusParityErr}, 8'h00);
    send(8'h1c, 1'b0, 1'b1);
    chk({7'h0, statusParityErr}, 8'h01);
    send(8'h33, 1'b1, 1'b0);
    chk({lastMouse, statusParityErr, lastOut[5:0]}, 8'hb3);
    cfgw(8'h20);
    n = nOut;
    send(8'h44, 1'b1, 1'b1);
    chk(8'(nOut - n), 8'h00);
    chk({7'h0, statusParityErr}, 8'h00);
    $display("test parity and mouse done");
    @(posedge core_clk);
    tblWe   <= 1'b1;
    tblAddr <= 8'h1c;
    tblData <= 8'h5a;
    @(posedge core_clk);
    tblWe <= 1'b0;
    cfgw(8'h40);
    send(8'h1c, 1'b0, 1'b0);
    chk(lastOut, 8'h5a);
    n = nOut;
    send(8'hf0, 1'b0, 1'b0);
    send(8'h1c, 1'b0, 1'b0);
    chk(lastOut, 8'hda);
    chk(8'(nOut - n), 8'h01);
    $display("test translate done");
    @(posedge core_clk);
    linkTimeout <= 1'b1;
    @(posedge core_clk);
    linkTimeout <= 1'b0;
    @(negedge core_clk);
    chk({7'h0, statusTimeout}, 8'h01);
    send(8'h1c, 1'b0, 1'b0);
    chk({7'h0, statusTimeout}, 8'h00);
    $display("test timeout done");
    n = nOut;
    @(posedge core_clk);
    sendReq   <= 1'b1;
    sendByte  <= 8'h1c;
    sendMouse <= 1'b0;
    sendBad   <= 1'b0;
    @(posedge core_clk);
    sendReq  <= 1'b0;
    cmdValid <= 1'b1;
    cmdCode  <= 8'h20;
    @(negedge core_clk);
    chk({7'h0, rxReady}, 8'h00);
    @(posedge core_clk);
    cmdValid <= 1'b0;
    @(negedge core_clk);
    chk({7'h0, rxReady}, 8'h01);
    @(negedge core_clk);
    chk(lastOut, 8'h40);
    @(negedge core_clk);
    chk(lastOut, 8'h5a);
    chk(8'(nOut - n), 8'h02);
    send(8'h1c, 1'b1, 1'b0);
    chk({lastMouse, lastOut[6:0]}, 8'h9c);
    $display("test stall and mouse done");
    send(8'h1c, 1'b0, 1'b1);
    @(posedge core_clk);
    linkTimeout <= 1'b1;
    @(posedge core_clk);
    linkTimeout <= 1'b0;
    reset       <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    chk(configByte, 8'h00);
    chk({4'h0, statusParityErr, statusTimeout, translateOn, mouseEnable}, 8'h01);
    cfgw(8'h40);
    send(8'h1c, 1'b0, 1'b0);
    chk(lastOut, 8'h1c);
    @(posedge core_clk);
    dataValid <= 1'b1;
    dataIn    <= 8'h55;
    @(posedge core_clk);
    dataValid <= 1'b0;
    cmd(8'h60);
    cfgr(8'h40);
    @(posedge core_clk);
    dataValid <= 1'b1;
    @(posedge core_clk);
    dataValid <= 1'b0;
    @(negedge core_clk);
    chk(configByte, 8'h40);
    $display("test reset and refusal done");
    final_report();
  end
endmodule

// ### tb/link_dev_model.sv
// Purpose: keyboard/mouse link device handing whole bytes to the controller
// Assumes: one byte in flight, held until the controller takes it
// Notes:   released data lines show the inverse of the last byte
module link_dev_model (
  input  wire logic       core_clk,    // core clock
  input  wire logic       sendReq,     // bench asks for a byte
  input  wire logic [7:0] sendByte,    // byte to send
  input  wire logic       sendMouse,   // byte is from the mouse
  input  wire logic       sendBad,     // send with even parity
  input  wire logic       rxReady,     // controller can take
  output logic            rxValid,     // byte present
  output logic      [7:0] rxData,      // byte
  output logic            rxParity,    // parity bit
  output logic            rxFromMouse  // source is mouse
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {rxValid, rxData, rxParity, rxFromMouse} = '0;
  always @(posedge core_clk) begin
    if (rxValid && rxReady) begin
      // no stale byte once released
      rxValid  <= 1'b0;
      rxData   <= ~rxData;
      rxParity <= ~rxParity;
    end else if (sendReq && !rxValid) begin
      rxValid     <= 1'b1;
      rxData      <= sendByte;
      rxParity    <= ~(^sendByte) ^ sendBad;
      rxFromMouse <= sendMouse;
    end
  end
endmodule
